// ### src/ide_drive_timing_select.sv
// per-drive timing selection, apb registers and cycle sequencer of one ide channel
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ide_timing_params.svh"
//
// How it works
// - drive 1 ready off forces ready true
// - drive 1 selected, enabled: sample ready
// - drive 1 fast off: compatible 16-bit data
// - drive 1 fast; pio only if dma-only clear
// - non-data ports always 8-bit compatible timing
// - drive 0 dma-only set slows pio only
// - drive 0 prefetch and posting when enabled
// - drive 0 ready off forces ready true
// - drive 0 selected, enabled: sample ready
// - drive 0 fast off: compatible 16-bit data
// - drive 0 fast; pio only if dma-only clear
// - slave register used only with its enable
// - slave register holds own timing, resets zero
// - slave sample point 5, 4, 3, 2 clocks
// - slave recovery 4, 3, 2 clocks
// - drive 1 prefetch and posting when enabled
module ide_drive_timing_select
  import ide_timing_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic [`ADDR_W-1:0]   paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 host_req,
  input  wire logic                 host_write,
  input  wire logic                 host_dma,
  input  wire logic [2:0]           host_addr,
  input  wire logic [15:0]          host_wdata,
  output logic      [15:0]          host_rdata,
  output logic                      host_ack,
  output logic      [2:0]           ide_addr,
  output logic      [1:0]           sec_io_strobe_n,
  input  wire logic                 sec_ready_in,
  input  wire logic [15:0]          ide_data_in,
  output logic      [15:0]          ide_data_out,
  output logic                      ide_data_oe
);
  strobe_if tif ();

  ide_strobe_timer u_timer (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .tif (tif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb registers

  logic [15:0] ide_channel_timing;
  logic [15:0] next_ide_channel_timing;
  logic [7:0]  slave_drive_timing;
  logic [7:0]  next_slave_drive_timing;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        apb_setup;
  logic        apb_write;
  logic        mapped;
  logic [31:0] status_word;

  main_state_t state;
  logic        drive_sel;
  logic        pref_valid;
  logic        cur_fast;

  assign apb_setup   = psel & ~penable;
  assign apb_write   = psel & penable & pwrite;
  assign pready      = 1'b1;
  assign mapped      = (paddr == `OFS_CHANNEL_TIMING) | (paddr == `OFS_SLAVE_TIMING) |
                       (paddr == `OFS_STATUS);
  assign status_word = {27'h0, cur_fast, tif.busy, (state != M_IDLE), pref_valid, drive_sel};

  always_comb begin
    next_ide_channel_timing = ide_channel_timing;
    next_slave_drive_timing = slave_drive_timing;
    next_prdata             = prdata;
    next_pslverr            = pslverr;
    if (apb_setup) begin
      next_pslverr = ~mapped;
      next_prdata  = 32'h0;
      unique case (paddr)
        `OFS_CHANNEL_TIMING: next_prdata = {16'h0, ide_channel_timing};
        `OFS_SLAVE_TIMING:   next_prdata = {24'h0, slave_drive_timing};
        `OFS_STATUS:         next_prdata = status_word;
        default:             next_prdata = 32'h0;
      endcase
    end
    if (apb_write) begin
      if (paddr == `OFS_CHANNEL_TIMING) begin
        next_ide_channel_timing = pwdata[15:0];
      end
      if (paddr == `OFS_SLAVE_TIMING) begin
        next_slave_drive_timing = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ide_channel_timing <= `RST_CHANNEL_TIMING;
      slave_drive_timing <= `RST_SLAVE_TIMING;
      prdata             <= 32'h0;
      pslverr            <= 1'b0;
    end else if (ce) begin
      ide_channel_timing <= next_ide_channel_timing;
      slave_drive_timing <= next_slave_drive_timing;
      prdata             <= next_prdata;
      pslverr            <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic        ready_meta;
  logic        ready_sync;
  logic [15:0] data_meta;
  logic [15:0] data_sync;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_meta <= 1'b0;
      ready_sync <= 1'b0;
      data_meta  <= 16'h0;
      data_sync  <= 16'h0;
    end else if (ce) begin
      ready_meta <= sec_ready_in;
      ready_sync <= ready_meta;
      data_meta  <= ide_data_in;
      data_sync  <= data_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timing selection for the latched cycle

  logic          cur_write;
  logic          cur_dma;
  logic          cur_pref;
  logic [2:0]    cur_addr;
  logic [15:0]   cur_wdata;
  logic          cur_data_port;
  logic          sel_fast_bit;
  logic          sel_dma_only;
  logic          sel_ready_en;
  logic          sel_pref_post;
  logic          use_slave;
  cycle_timing_t fast_timing;
  cycle_timing_t main_fast;
  cycle_timing_t slave_fast;
  logic [1:0]    slv_rec_code;

  assign cur_data_port = (cur_addr == `DATA_PORT);
  assign sel_fast_bit  = drive_sel ? ide_channel_timing[`B_FAST_SEL_DRV1]
                                   : ide_channel_timing[`B_FAST_SEL_DRV0];
  assign sel_dma_only  = drive_sel ? ide_channel_timing[`B_DMA_ONLY_DRV1]
                                   : ide_channel_timing[`B_DMA_ONLY_DRV0];
  assign sel_ready_en  = drive_sel ? ide_channel_timing[`B_READY_EN_DRV1]
                                   : ide_channel_timing[`B_READY_EN_DRV0];
  assign sel_pref_post = drive_sel ? ide_channel_timing[`B_PREF_POST_DRV1]
                                   : ide_channel_timing[`B_PREF_POST_DRV0];
  assign use_slave     = drive_sel & ide_channel_timing[`B_SLAVE_TREG_EN];

  assign cur_fast = cur_data_port & sel_fast_bit & (cur_dma | ~sel_dma_only);

  assign main_fast.sample  = `SAMPLE_BASE -
                             {1'b0, ide_channel_timing[`F_SAMPLE_LO +: 2]};
  assign main_fast.recov   = `RECOV_BASE -
                             {1'b0, ide_channel_timing[`F_RECOV_LO +: 2]};
  assign slave_fast.sample = `SAMPLE_BASE -
                             {1'b0, slave_drive_timing[`F_SEC_SLV_SAMPLE_LO +: 2]};
  assign slv_rec_code      = slave_drive_timing[`F_SEC_SLV_RECOV_LO +: 2];
  assign slave_fast.recov  = (slv_rec_code == 2'h3) ? `SLV_RECOV_FLOOR
                                                    : `RECOV_BASE - {1'b0, slv_rec_code};
  assign fast_timing       = use_slave ? slave_fast : main_fast;

  always_comb begin
    if (!cur_data_port) begin
      tif.timing.sample = `COMPAT8_SAMPLE;
      tif.timing.recov  = `COMPAT8_RECOV;
    end else if (cur_fast) begin
      tif.timing = fast_timing;
    end else begin
      tif.timing.sample = `COMPAT16_SAMPLE;
      tif.timing.recov  = `COMPAT16_RECOV;
    end
  end

  assign tif.ready_force = ~sel_ready_en;
  assign tif.ready_pin   = ready_sync;

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer with one-word prefetch

  main_state_t next_state;
  logic        next_drive_sel;
  logic        next_pref_valid;
  logic [15:0] pref_data;
  logic [15:0] next_pref_data;
  logic        next_cur_write;
  logic        next_cur_dma;
  logic        next_cur_pref;
  logic [2:0]  next_cur_addr;
  logic [15:0] next_cur_wdata;
  logic        posted;
  logic        next_posted;
  logic [15:0] next_host_rdata;
  logic        next_host_ack;
  logic        decode_en;
  logic        req_pio_data;
  logic        cur_pio_pp;

  assign decode_en    = ide_channel_timing[`B_DECODE_EN];
  assign req_pio_data = (host_addr == `DATA_PORT) & ~host_dma;
  assign cur_pio_pp   = cur_data_port & ~cur_dma & sel_pref_post;

  always_comb begin
    next_state      = state;
    next_drive_sel  = drive_sel;
    next_pref_valid = pref_valid;
    next_pref_data  = pref_data;
    next_cur_write  = cur_write;
    next_cur_dma    = cur_dma;
    next_cur_pref   = cur_pref;
    next_cur_addr   = cur_addr;
    next_cur_wdata  = cur_wdata;
    next_posted     = posted;
    next_host_rdata = host_rdata;
    next_host_ack   = 1'b0;
    tif.start       = 1'b0;
    unique case (state)
      M_IDLE: begin
        if (host_req && !host_ack) begin
          if (!decode_en) begin
            next_host_ack   = 1'b1;
            next_host_rdata = `FLOAT_DATA;
          end else if (!host_write && req_pio_data && pref_valid) begin
            next_host_ack   = 1'b1;
            next_host_rdata = pref_data;
            next_pref_valid = 1'b0;
            next_cur_pref   = 1'b1;
            next_state      = sel_pref_post ? M_START : M_IDLE;
          end else begin
            next_cur_write  = host_write;
            next_cur_dma    = host_dma;
            next_cur_addr   = host_addr;
            next_cur_wdata  = host_wdata;
            next_cur_pref   = 1'b0;
            next_posted     = host_write & req_pio_data & sel_pref_post;
            next_host_ack   = host_write & req_pio_data & sel_pref_post;
            next_state      = M_START;
            if (host_write) begin
              next_pref_valid = 1'b0;
            end
            if (host_write && host_addr == `DRIVE_HEAD_PORT) begin
              next_drive_sel  = host_wdata[`B_DRIVE_SEL];
              next_pref_valid = 1'b0;
            end
          end
        end
      end
      M_START: begin
        if (!tif.busy) begin
          tif.start  = 1'b1;
          next_state = M_CYCLE;
        end
      end
      M_CYCLE: begin
        if (tif.done) begin
          if (cur_pref) begin
            next_pref_valid = 1'b1;
            next_pref_data  = data_sync;
            next_state      = M_IDLE;
          end else begin
            next_host_ack   = ~posted;
            next_host_rdata = cur_write ? host_rdata : data_sync;
            next_posted     = 1'b0;
            next_cur_pref   = ~cur_write & cur_pio_pp;
            next_state      = (~cur_write & cur_pio_pp) ? M_START : M_IDLE;
          end
        end
      end
      default: next_state = M_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= M_IDLE;
      drive_sel  <= 1'b0;
      pref_valid <= 1'b0;
      pref_data  <= 16'h0;
      cur_write  <= 1'b0;
      cur_dma    <= 1'b0;
      cur_pref   <= 1'b0;
      cur_addr   <= 3'h0;
      cur_wdata  <= 16'h0;
      posted     <= 1'b0;
      host_rdata <= 16'h0;
      host_ack   <= 1'b0;
    end else if (ce) begin
      state      <= next_state;
      drive_sel  <= next_drive_sel;
      pref_valid <= next_pref_valid;
      pref_data  <= next_pref_data;
      cur_write  <= next_cur_write;
      cur_dma    <= next_cur_dma;
      cur_pref   <= next_cur_pref;
      cur_addr   <= next_cur_addr;
      cur_wdata  <= next_cur_wdata;
      posted     <= next_posted;
      host_rdata <= next_host_rdata;
      host_ack   <= next_host_ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive side pins

  assign ide_addr        = cur_addr;
  assign ide_data_out    = cur_wdata;
  assign ide_data_oe     = cur_write & (state == M_CYCLE);
  assign sec_io_strobe_n = {~(tif.strobe & cur_write), ~(tif.strobe & ~cur_write)};
endmodule
`default_nettype wire

// ### shared/ide_timing_params.svh
// offsets, field positions, reset values and cycle counts of the drive timing block
`ifndef IDE_TIMING_PARAMS_SVH
`define IDE_TIMING_PARAMS_SVH

`define ADDR_W                12
`define OFS_CHANNEL_TIMING    12'h040
`define OFS_SLAVE_TIMING      12'h044
`define OFS_STATUS            12'h048

`define RST_CHANNEL_TIMING    16'h0000
`define RST_SLAVE_TIMING      8'h00

`define B_FAST_SEL_DRV0       0
`define B_READY_EN_DRV0       1
`define B_PREF_POST_DRV0      2
`define B_DMA_ONLY_DRV0       3
`define B_FAST_SEL_DRV1       4
`define B_READY_EN_DRV1       5
`define B_PREF_POST_DRV1      6
`define B_DMA_ONLY_DRV1       7
`define F_RECOV_LO            8
`define F_SAMPLE_LO           12
`define B_SLAVE_TREG_EN       14
`define B_DECODE_EN           15
`define F_SEC_SLV_RECOV_LO    4
`define F_SEC_SLV_SAMPLE_LO   6

`define DATA_PORT             3'h0
`define DRIVE_HEAD_PORT       3'h6
`define B_DRIVE_SEL           4

`define SAMPLE_BASE           3'h5
`define RECOV_BASE            3'h4
`define SLV_RECOV_FLOOR       3'h2
`define COMPAT16_SAMPLE       3'h5
`define COMPAT16_RECOV        3'h4
`define COMPAT8_SAMPLE        3'h6
`define COMPAT8_RECOV         3'h7
`define FLOAT_DATA            16'hffff

`endif

// ### shared/ide_timing_pkg.sv
// types shared by the drive timing block
package ide_timing_pkg;
  typedef enum logic [1:0] {M_IDLE, M_START, M_CYCLE} main_state_t;
  typedef enum logic [1:0] {T_IDLE, T_ACTIVE, T_RECOV} timer_state_t;
  typedef struct packed {
    logic [2:0] sample;
    logic [2:0] recov;
  } cycle_timing_t;
endpackage

// ### shared/strobe_if.sv
// carrier between the cycle sequencer and the strobe timer
`timescale 1ns/1ps
`default_nettype none
interface strobe_if;
  import ide_timing_pkg::*;
  logic          start;
  cycle_timing_t timing;
  logic          ready_force;
  logic          ready_pin;
  logic          strobe;
  logic          busy;
  logic          done;
  modport main  (output start, timing, ready_force, ready_pin, input strobe, busy, done);
  modport timer (input start, timing, ready_force, ready_pin, output strobe, busy, done);
endinterface
`default_nettype wire

// ### src/ide_strobe_timer.sv
// strobe, ready sample point and recovery timer for one channel
`timescale 1ns/1ps
`default_nettype none
`include "ide_timing_params.svh"
module ide_strobe_timer
  import ide_timing_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  strobe_if.timer   tif
);
  timer_state_t state;
  timer_state_t next_state;
  logic [2:0]   count;
  logic [2:0]   next_count;
  logic         ready_ok;

  assign ready_ok   = tif.ready_force | tif.ready_pin;
  assign tif.strobe = (state == T_ACTIVE);
  assign tif.busy   = (state != T_IDLE);

  always_comb begin
    next_state = state;
    next_count = count;
    tif.done   = 1'b0;
    unique case (state)
      T_IDLE: begin
        if (tif.start) begin
          next_count = tif.timing.sample - 3'h1;
          next_state = T_ACTIVE;
        end
      end
      T_ACTIVE: begin
        if (count != 3'h0) begin
          next_count = count - 3'h1;
        end else if (ready_ok) begin
          // forced ready passes the first sample point
          tif.done   = 1'b1;
          next_count = tif.timing.recov - 3'h1;
          next_state = T_RECOV;
        end
      end
      T_RECOV: begin
        if (count != 3'h0) begin
          next_count = count - 3'h1;
        end else begin
          next_state = T_IDLE;
        end
      end
      default: next_state = T_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= T_IDLE;
      count <= 3'h0;
    end else if (ce) begin
      state <= next_state;
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

// ### test/ide_drive_model.sv
// far-side drive model: read data, ready and write capture
`timescale 1ns/1ps
`default_nettype none
module ide_drive_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [1:0]  strobe_n,
  input  wire logic [2:0]  addr,
  input  wire logic [15:0] dout,
  input  wire logic        oe,
  input  wire logic [3:0]  rdy_delay,
  output logic             rdy,
  output logic      [15:0] din,
  output logic      [15:0] wr_word
);
  logic [3:0]  cnt;
  logic [15:0] last;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt     <= 4'h0;
      last    <= 16'h0000;
      wr_word <= 16'h0000;
    end else begin
      cnt <= (&strobe_n) ? 4'h0 : cnt + {3'h0, cnt != 4'hf};
      if (!strobe_n[0]) last <= din;
      if (!strobe_n[1] && oe) wr_word <= dout;
    end
  end
  // ready pulled high when idle, released data shows the inverse
  assign rdy = (&strobe_n) || (cnt >= rdy_delay);
  assign din = !strobe_n[0] ? (16'hc3a0 | {13'h0, addr}) : ~last;
endmodule
`default_nettype wire

// ### test/ide_drive_timing_select_checker.sv
// port assertions for the drive timing block
`timescale 1ns/1ps
`default_nettype none
`include "ide_timing_params.svh"
module ide_drive_timing_select_checker (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [15:0]        host_rdata,
  input wire logic               host_ack,
  input wire logic [1:0]         sec_io_strobe_n,
  input wire logic               ide_data_oe
);
  logic acc;
  logic mapped;
  assign acc = psel && penable;
  assign mapped = paddr inside {`OFS_CHANNEL_TIMING, `OFS_SLAVE_TIMING, `OFS_STATUS};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_pready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access flagged");
  a_err_read_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  a_ack_pulse: assert property (host_ack |=> !host_ack)
    else $error("ack longer than one cycle");
  a_rdata_with_ack: assert property ($changed(host_rdata) |-> $rose(host_ack))
    else $error("host data moved without ack");
  a_strobe_excl: assert property (sec_io_strobe_n != 2'b00)
    else $error("both strobes low");
  a_oe_on_write: assert property (!sec_io_strobe_n[1] |-> ide_data_oe)
    else $error("write strobe without drive");
  a_strobe_min: assert property ($fell(sec_io_strobe_n[0]) |=> !sec_io_strobe_n[0])
    else $error("read strobe too short");
  a_ack_strobe_idle: assert property (host_ack |-> sec_io_strobe_n == 2'b11)
    else $error("ack while strobe active");
endmodule
bind ide_drive_timing_select ide_drive_timing_select_checker ide_drive_timing_select_checker_inst (
  .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_rdata(host_rdata),
  .host_ack(host_ack), .sec_io_strobe_n(sec_io_strobe_n), .ide_data_oe(ide_data_oe));
`default_nettype wire

// ### test/ide_drive_timing_select_tb_top.sv
// self-checking bench for the drive timing block
`timescale 1ns/1ps
`default_nettype none
module ide_drive_timing_select_tb_top;
  typedef struct {
    logic [15:0] ctl;
    logic [7:0]  slv;
    logic        drv;
    logic [2:0]  port;
    logic        dma;
    logic        wr;
    int          ns;
  } row_t;
  logic        clk, rst, psel, penable, pwrite, host_req, host_write, host_dma;
  logic        pready, pslverr, host_ack, sec_ready_in, ide_data_oe, e, ce;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0]  host_addr, ide_addr;
  logic [15:0] host_wdata, host_rdata, ide_data_in, ide_data_out, wr_word, d;
  logic [1:0]  sec_io_strobe_n;
  logic [3:0]  rdy_delay;
  int          err_total, n_tests, cyc, n, g;
  row_t        rows [16] = '{
    '{16'h0000, 8'h00, '0, 3'd0, '0, '0, 0}, '{16'h8000, 8'h00, '0, 3'd0, '0, '0, 5},
    '{16'h8000, 8'h00, '0, 3'd1, '0, '0, 6}, '{16'ha001, 8'h00, '0, 3'd0, '0, '0, 3},
    '{16'ha001, 8'h00, '0, 3'd7, '0, '0, 6}, '{16'ha009, 8'h00, '0, 3'd0, '0, '0, 5},
    '{16'ha009, 8'h00, '0, 3'd0, '1, '0, 3}, '{16'ha001, 8'h00, '0, 3'd0, '0, '1, 3},
    '{16'h9010, 8'h00, '1, 3'd0, '0, '0, 4}, '{16'h9090, 8'h00, '1, 3'd0, '0, '0, 5},
    '{16'h9090, 8'h00, '1, 3'd0, '1, '1, 4}, '{16'h9001, 8'h00, '1, 3'd0, '0, '0, 5},
    '{16'hd010, 8'h80, '1, 3'd0, '0, '0, 3}, '{16'hc010, 8'h40, '1, 3'd0, '0, '0, 4},
    '{16'h9010, 8'h80, '1, 3'd0, '0, '0, 4}, '{16'hd011, 8'h80, '0, 3'd0, '0, '0, 4}};
  ide_drive_timing_select ide_drive_timing_select_inst (
    .clk(clk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_req(host_req), .host_write(host_write), .host_dma(host_dma), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_ack(host_ack), .ide_addr(ide_addr),
    .sec_io_strobe_n(sec_io_strobe_n), .sec_ready_in(sec_ready_in), .ide_data_in(ide_data_in),
    .ide_data_out(ide_data_out), .ide_data_oe(ide_data_oe));
  ide_drive_model ide_drive_model_inst (
    .clk(clk), .rst(rst), .strobe_n(sec_io_strobe_n), .addr(ide_addr), .dout(ide_data_out),
    .oe(ide_data_oe), .rdy_delay(rdy_delay), .rdy(sec_ready_in), .din(ide_data_in),
    .wr_word(wr_word));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic host(input logic w, dm, input logic [2:0] a, input logic [15:0] wd, input logic h);
    host_write <= w;
    host_dma   <= dm;
    host_addr  <= a;
    host_wdata <= wd;
    host_req   <= 1'b1;
    n = 0;
    g = 0;
    for (int k = 0; k < 300; k++) begin
      @(posedge clk);
      if (sec_io_strobe_n !== 2'b11) n++;
      else if (n == 0) g++;
      if (host_ack === 1'b1) break;
    end
    if (host_ack !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t host cycle not acknowledged", $time);
    end
    d = host_rdata;
    if (!h) begin
      host_req <= 1'b0;
      @(posedge clk);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc > 20000) begin
        err_total++;
        print_verdict;
      end
    end
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {host_req, host_write, host_dma, host_addr, host_wdata, rdy_delay} = 26'h0;
    ce = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 12'h040, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 12'h044, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, 12'h044, 32'hffff_ffa5);
    apb(1'b0, 12'h044, 32'h0);
    chk(r, 32'h0000_00a5);
    apb(1'b0, 12'h04c, 32'h0);
    chk({r[30:0], e}, 32'h1);
    $display("test registers done");
    foreach (rows[i]) begin
      apb(1'b1, 12'h040, {16'h0, rows[i].ctl});
      apb(1'b1, 12'h044, {24'h0, rows[i].slv});
      host(1'b1, 1'b0, 3'h6, {11'h0, rows[i].drv, 4'h0}, 1'b0);
      host(rows[i].wr, rows[i].dma, rows[i].port, 16'h5a30 + 16'(i), 1'b0);
      chk(n, rows[i].ns);
      if (rows[i].wr) chk(wr_word, 16'h5a30 + 16'(i));
      else chk(d, rows[i].ctl[15] ? 16'hc3a0 | rows[i].port : 16'hffff);
      $display("test row %0d done", i);
    end
    rdy_delay <= 4'h8;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h040, k[1] ? 32'h8020 : 32'h8002);
      host(1'b1, 1'b0, 3'h6, {11'h0, k[0], 4'h0}, 1'b0);
      host(1'b0, 1'b0, 3'h0, 16'h0, 1'b0);
      chk(n > 8, k[0] == k[1]);
    end
    rdy_delay <= 4'h0;
    $display("test ready done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h040, k[0] ? (k[1] ? 32'h8040 : 32'h8004) : 32'h8000);
      host(1'b1, 1'b0, 3'h6, {11'h0, k[1], 4'h0}, 1'b0);
      host(1'b0, 1'b0, 3'h0, 16'h0, 1'b0);
      apb(1'b0, 12'h048, 32'h0);
      while (r[3:2] !== 2'b00) apb(1'b0, 12'h048, 32'h0);
      chk(r[1:0], {k[0], k[1]});
    end
    host(1'b0, 1'b0, 3'h0, 16'h0, 1'b0);
    chk(n, 0);
    chk(d, 16'hc3a0);
    host(1'b1, 1'b0, 3'h0, 16'h7e11, 1'b0);
    chk(wr_word == 16'h7e11, 1'b0);
    apb(1'b0, 12'h048, 32'h0);
    while (r[3:2] !== 2'b00) apb(1'b0, 12'h048, 32'h0);
    chk(wr_word, 16'h7e11);
    $display("test prefetch done");
    apb(1'b1, 12'h040, 32'hc010);
    host(1'b1, 1'b0, 3'h6, 16'h0010, 1'b0);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, 12'h044, k << 4);
      host(1'b0, 1'b0, 3'h0, 16'h0, 1'b1);
      host(1'b0, 1'b0, 3'h0, 16'h0, 1'b0);
      chk(g, 4 - k);
    end
    $display("test recovery done");
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    ce  <= 1'b0;
    @(posedge clk);
    apb(1'b1, 12'h044, 32'h0000_00ff);
    ce <= 1'b1;
    apb(1'b0, 12'h044, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 12'h048, 32'h0);
    chk(r, 32'h0);
    $display("test reset done");
    print_verdict;
  end
endmodule
`default_nettype wire
